// ---- isbmc_consts.vh ----
// Constants for the idle standby mode controller.
`ifndef ISBMC_CONSTS_VH
`define ISBMC_CONSTS_VH
`define ISBMC_ADDR_W 2
`define ISBMC_ADDR_MODE 2'h0
`define ISBMC_ADDR_CTRL 2'h1
`define ISBMC_ADDR_STAB 2'h2
`define ISBMC_ADDR_STAT 2'h3
`define ISBMC_MODE_LIGHT 2'h0
`define ISBMC_MODE_DEEP 2'h2
`define ISBMC_CTRL_STOP 0
`define ISBMC_CTRL_MASKABLE_WAKE_MASK 4
`define ISBMC_CTRL_NONMASK1_WAKE_MASK 5
`define ISBMC_CTRL_NONMASK2_WAKE_MASK 6
`define ISBMC_CTRL_RST 8'h00
`define ISBMC_STAB_RST 3'h4
`define ISBMC_STAB_BASE 4'h4
`define ISBMC_EXT_W 8
`define ISBMC_PERI_W 8
`define ISBMC_ST_NORMAL 2'h0
`define ISBMC_ST_LIGHT 2'h1
`define ISBMC_ST_DEEP 2'h2
`define ISBMC_ST_STAB 2'h3
`endif

// ---- isbmc_idle_ctrl.v ----
// Idle standby mode controller: light and deep idle entry, clock gating and wake-up.
`include "isbmc_consts.vh"
module isbmc_idle_ctrl (
    input wire sys_clk_i,
    input wire srst_i,
    input wire ce_i,
    input wire [`ISBMC_ADDR_W-1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire nonmask_pin_i,
    input wire watchdog_overflow_irq_i,
    input wire [`ISBMC_EXT_W-1:0] external_irq_i,
    input wire [`ISBMC_PERI_W-1:0] peri_irq_i,
    input wire irq_enabled_state_i,
    input wire in_service_i,
    input wire irq_higher_i,
    input wire interval_timer_ring_div8_i,
    input wire watchdog_unit_ring_i,
    input wire clocked_serial_b_ext_i,
    input wire async_serial_unit_ext_i,
    output reg cpu_clk_en_o,
    output reg peri_clk_en_o,
    output reg pll_en_o,
    output reg flash_pump_en_o,
    output reg osc_en_o,
    output reg wake_detect_en_o,
    output reg interval_timer_en_o,
    output reg watchdog_unit_en_o,
    output reg clocked_serial_b_en_o,
    output reg async_serial_unit_en_o,
    output reg hold_state_o,
    output reg wake_ack_o,
    output reg wake_branch_o,
    output reg [1:0] mode_state_o
);
    reg [1:0] save_mode_select_field;
    reg [7:0] power_save_control_reg;
    reg [2:0] stabilization_time_select;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [1:0] nmi_sync1;
    reg [1:0] nmi_sync2;
    reg [`ISBMC_EXT_W-1:0] ext_sync1;
    reg [`ISBMC_EXT_W-1:0] ext_sync2;
    reg stab_start;
    wire stab_done;
    wire nonmask2_wake_mask;
    wire nonmask1_wake_mask;
    wire maskable_wake_mask;
    wire nmi_wake;
    wire mask_wake;
    wire any_wake;
    wire idle;
    wire stop_req;

    assign nonmask2_wake_mask = power_save_control_reg[`ISBMC_CTRL_NONMASK2_WAKE_MASK];
    assign nonmask1_wake_mask = power_save_control_reg[`ISBMC_CTRL_NONMASK1_WAKE_MASK];
    assign maskable_wake_mask = power_save_control_reg[`ISBMC_CTRL_MASKABLE_WAKE_MASK];
    assign idle = (state == `ISBMC_ST_LIGHT) || (state == `ISBMC_ST_DEEP);

    // External pins are asynchronous and pass two flops before use.
    always @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            nmi_sync1 <= 2'h0;
            nmi_sync2 <= 2'h0;
            ext_sync1 <= {`ISBMC_EXT_W{1'b0}};
            ext_sync2 <= {`ISBMC_EXT_W{1'b0}};
        end
        else if (ce_i)
        begin
            nmi_sync1 <= {nonmask_pin_i, 1'b0};
            nmi_sync2 <= nmi_sync1;
            ext_sync1 <= external_irq_i;
            ext_sync2 <= ext_sync1;
        end
    end

    // Mask bits set to one remove a source from the wake set.
    assign nmi_wake = (nmi_sync2[1] & ~nonmask1_wake_mask) |
        (watchdog_overflow_irq_i & ~nonmask2_wake_mask);
    assign mask_wake = ~maskable_wake_mask & ((|ext_sync2) | (|peri_irq_i));
    assign any_wake = nmi_wake | mask_wake;

    assign stop_req = wr_i && (addr_i == `ISBMC_ADDR_CTRL) && wdata_i[`ISBMC_CTRL_STOP];

    always @*
    begin
        next_state = state;
        stab_start = 1'b0;
        case (state)
            `ISBMC_ST_NORMAL:
            begin
                // Only normal operation accepts an idle request.
                if (stop_req && save_mode_select_field == `ISBMC_MODE_LIGHT)
                    next_state = `ISBMC_ST_LIGHT;
                else if (stop_req && save_mode_select_field == `ISBMC_MODE_DEEP)
                    next_state = `ISBMC_ST_DEEP;
            end
            `ISBMC_ST_LIGHT:
            begin
                if (any_wake)
                    next_state = `ISBMC_ST_NORMAL;
            end
            `ISBMC_ST_DEEP:
            begin
                if (any_wake)
                begin
                    next_state = `ISBMC_ST_STAB;
                    stab_start = 1'b1;
                end
            end
            `ISBMC_ST_STAB:
            begin
                if (stab_done)
                    next_state = `ISBMC_ST_NORMAL;
            end
            default:
                next_state = `ISBMC_ST_NORMAL;
        endcase
    end

    isbmc_stab_timer u_stab (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .start_i(stab_start),
        .sel_i(stabilization_time_select),
        .done_o(stab_done)
    );

    // Reset restores every register identically whatever the mode was.
    always @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            state <= `ISBMC_ST_NORMAL;
            save_mode_select_field <= `ISBMC_MODE_LIGHT;
            power_save_control_reg <= `ISBMC_CTRL_RST;
            stabilization_time_select <= `ISBMC_STAB_RST;
            rdata_o <= 8'h00;
            cpu_clk_en_o <= 1'b1;
            peri_clk_en_o <= 1'b1;
            pll_en_o <= 1'b1;
            flash_pump_en_o <= 1'b1;
            osc_en_o <= 1'b1;
            wake_detect_en_o <= 1'b1;
            interval_timer_en_o <= 1'b1;
            watchdog_unit_en_o <= 1'b1;
            clocked_serial_b_en_o <= 1'b1;
            async_serial_unit_en_o <= 1'b1;
            hold_state_o <= 1'b0;
            wake_ack_o <= 1'b0;
            wake_branch_o <= 1'b0;
            mode_state_o <= `ISBMC_ST_NORMAL;
        end
        else if (ce_i)
        begin
            state <= next_state;
            mode_state_o <= next_state;
            if (wr_i && addr_i == `ISBMC_ADDR_MODE)
                save_mode_select_field <= wdata_i[1:0];
            // Stop bit self-clears: it is a trigger, not a level.
            if (wr_i && addr_i == `ISBMC_ADDR_CTRL)
                power_save_control_reg <= wdata_i & ~(8'h01 << `ISBMC_CTRL_STOP);
            if (wr_i && addr_i == `ISBMC_ADDR_STAB)
                stabilization_time_select <= wdata_i[2:0];
            rdata_o <= 8'h00;
            if (rd_i)
            begin
                case (addr_i)
                    `ISBMC_ADDR_MODE: rdata_o <= {6'h00, save_mode_select_field};
                    `ISBMC_ADDR_CTRL: rdata_o <= power_save_control_reg;
                    `ISBMC_ADDR_STAB: rdata_o <= {5'h00, stabilization_time_select};
                    `ISBMC_ADDR_STAT: rdata_o <= {6'h00, state};
                    default: rdata_o <= 8'h00;
                endcase
            end
            // Gating follows next_state so clocks stop the cycle the mode is entered.
            cpu_clk_en_o <= (next_state == `ISBMC_ST_NORMAL);
            peri_clk_en_o <= (next_state == `ISBMC_ST_NORMAL);
            pll_en_o <= (next_state != `ISBMC_ST_DEEP);
            flash_pump_en_o <= (next_state != `ISBMC_ST_DEEP);
            osc_en_o <= 1'b1;
            wake_detect_en_o <= 1'b1;
            interval_timer_en_o <= (next_state == `ISBMC_ST_NORMAL) ||
                interval_timer_ring_div8_i;
            watchdog_unit_en_o <= (next_state == `ISBMC_ST_NORMAL) ||
                watchdog_unit_ring_i;
            clocked_serial_b_en_o <= (next_state == `ISBMC_ST_NORMAL) ||
                clocked_serial_b_ext_i;
            async_serial_unit_en_o <= (next_state == `ISBMC_ST_NORMAL) ||
                async_serial_unit_ext_i;
            // Holding freezes CPU and port state; nothing is cleared on entry.
            hold_state_o <= (next_state != `ISBMC_ST_NORMAL);
            wake_ack_o <= 1'b0;
            wake_branch_o <= 1'b0;
            if (idle && any_wake)
            begin
                // Outside a handler every wake is taken; inside only a higher one or a non-maskable one.
                wake_ack_o <= nmi_wake || !in_service_i || irq_higher_i;
                // Masked-by-disable requests resume at the next instruction.
                wake_branch_o <= nmi_wake ||
                    (irq_enabled_state_i && (!in_service_i || irq_higher_i));
            end
        end
    end
endmodule

// ---- isbmc_idle_ctrl_properties.sv ----
// Port-level checks for the idle standby controller.
module isbmc_chk (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic cpu_clk_en_o,
    input wire logic peri_clk_en_o,
    input wire logic pll_en_o,
    input wire logic flash_pump_en_o,
    input wire logic osc_en_o,
    input wire logic hold_state_o,
    input wire logic wake_ack_o,
    input wire logic [1:0] mode_state_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    property p_light;
        mode_state_o == 2'h1 |-> !cpu_clk_en_o && !peri_clk_en_o && pll_en_o
            && flash_pump_en_o && osc_en_o;
    endproperty
    a_light: assert property (p_light) else $error("light idle gating wrong");
    property p_deep;
        mode_state_o == 2'h2 |-> !cpu_clk_en_o && !peri_clk_en_o && !pll_en_o && osc_en_o;
    endproperty
    a_deep: assert property (p_deep) else $error("deep idle gating wrong");
    property p_hold;
        mode_state_o != 2'h0 |-> hold_state_o;
    endproperty
    a_hold: assert property (p_hold) else $error("state not held in idle");
    property p_fast;
        mode_state_o == 2'h1 ##1 mode_state_o != 2'h1 |-> mode_state_o == 2'h0;
    endproperty
    a_fast: assert property (p_fast) else $error("light exit not direct");
    property p_slow;
        mode_state_o == 2'h2 ##1 mode_state_o != 2'h2 |-> mode_state_o == 2'h3;
    endproperty
    a_slow: assert property (p_slow) else $error("deep exit skipped wait");
    property p_ack;
        wake_ack_o |-> $past(mode_state_o) inside {2'h1, 2'h2};
    endproperty
    a_ack: assert property (p_ack) else $error("ack outside wake");
    property p_stab;
        $rose(mode_state_o == 2'h3) |-> (mode_state_o == 2'h3) [*8];
    endproperty
    a_stab: assert property (p_stab) else $error("stabilization too short");
    property p_seq;
        mode_state_o == 2'h1 |=> mode_state_o != 2'h2 && mode_state_o != 2'h3;
    endproperty
    a_seq: assert property (p_seq) else $error("idle request taken in idle");
    property p_rst;
        disable iff (1'b0) srst_i |=> mode_state_o == 2'h0 && cpu_clk_en_o && !hold_state_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    c_light: cover property (mode_state_o == 2'h1);
    c_deep: cover property (mode_state_o == 2'h2);
    c_stab: cover property (mode_state_o == 2'h3 ##1 mode_state_o == 2'h0);
endmodule
bind isbmc_idle_ctrl isbmc_chk u_isbmc_chk (.*);

// ---- isbmc_stab_timer.v ----
// Oscillation stabilization timer that counts until an overflow.
`include "isbmc_consts.vh"
module isbmc_stab_timer (
    input wire sys_clk_i,
    input wire srst_i,
    input wire ce_i,
    input wire start_i,
    input wire [2:0] sel_i,
    output reg done_o
);
    reg [15:0] cnt;
    reg run;
    wire [15:0] lim;
    wire [3:0] shift;

    // Count length is two to the power of base plus selection.
    assign shift = `ISBMC_STAB_BASE + {1'b0, sel_i};
    assign lim = (16'h0001 << shift) - 16'h0001;

    always @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            cnt <= 16'h0000;
            run <= 1'b0;
            done_o <= 1'b0;
        end
        else if (ce_i)
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                cnt <= 16'h0000;
                run <= 1'b1;
            end
            else if (run)
            begin
                if (cnt == lim)
                begin
                    run <= 1'b0;
                    done_o <= 1'b1;
                end
                else
                begin
                    cnt <= cnt + 16'h0001;
                end
            end
        end
    end
endmodule

// ---- isbmc_wake_src.sv ----
// Wake source model: each request level stays up until the controller is back to normal.
module isbmc_wake_src (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [3:0] fire_i,
    input wire logic [1:0] mode_i,
    output logic [3:0] req_o = 4'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic seen = 1'b0;
    always @(posedge sys_clk_i)
    begin
        if (srst_i || (seen && mode_i == 2'h0))
        begin
            req_o <= 4'h0;
            seen <= 1'b0;
        end
        else
        begin
            req_o <= req_o | fire_i;
            seen <= seen | (mode_i != 2'h0);
        end
    end
endmodule

// ---- tb.sv ----
// Self-checking bench for the idle standby controller.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 0, srst_i = 1, wr = 0, rd = 0, ins = 0, hi = 0, en = 0, its = 0;
    logic [1:0] addr = 0, mode;
    logic [7:0] wd = 0, rdata, e;
    logic [3:0] fire = 0, req;
    logic cpu, pll, flash, osc, it_en, hold, ack, br, peri, wdet, wd_en, csb, asu;
    logic [7:0] tbl [6] = '{8'h10, 8'h2c, 8'h42, 8'h40, 8'h8a, 8'h8e};
    int error_cnt = 0, checks_done = 0, n;
    isbmc_idle_ctrl u_isbmc_idle_ctrl (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(1'b1),
        .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .nonmask_pin_i(req[0]), .watchdog_overflow_irq_i(req[1]),
        .external_irq_i({7'h00, req[2]}), .peri_irq_i({7'h00, req[3]}),
        .irq_enabled_state_i(en), .in_service_i(ins), .irq_higher_i(hi),
        .interval_timer_ring_div8_i(its), .watchdog_unit_ring_i(1'b1),
        .clocked_serial_b_ext_i(its), .async_serial_unit_ext_i(1'b0),
        .cpu_clk_en_o(cpu), .peri_clk_en_o(peri), .pll_en_o(pll), .flash_pump_en_o(flash),
        .osc_en_o(osc), .wake_detect_en_o(wdet), .interval_timer_en_o(it_en),
        .watchdog_unit_en_o(wd_en), .clocked_serial_b_en_o(csb), .async_serial_unit_en_o(asu),
        .hold_state_o(hold), .wake_ack_o(ack), .wake_branch_o(br), .mode_state_o(mode));
    isbmc_wake_src u_isbmc_wake_src (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .fire_i(fire),
        .mode_i(mode), .req_o(req));
    initial
    begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        // One idle cycle keeps back-to-back writes from driving wr twice in a step.
        wr <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] x);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        @(posedge sys_clk_i);
        chk(rdata, x);
    endtask
    task automatic wait_mode(input logic [1:0] m);
        n = 0;
        while (mode !== m && n < 300)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n == 300)
        begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic enter_wake(input logic [7:0] ctl, input logic [3:0] src);
        wr_reg(2'h1, ctl);
        repeat (6) @(posedge sys_clk_i);
        fire <= src;
        @(posedge sys_clk_i);
        fire <= 4'h0;
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd_reg(2'h0, 8'h00);
        rd_reg(2'h1, 8'h00);
        rd_reg(2'h2, 8'h04);
        wr_reg(2'h3, 8'h02);
        rd_reg(2'h3, 8'h00);
        wr_reg(2'h0, 8'h01);
        wr_reg(2'h1, 8'h01);
        rd_reg(2'h3, 8'h00);
        wr_reg(2'h0, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            // Let a synchronised pin request drain before the next idle entry.
            repeat (4) @(posedge sys_clk_i);
            ins <= tbl[k][3];
            hi <= tbl[k][2];
            en <= tbl[k][1];
            its <= k[0];
            wr_reg(2'h1, 8'h01);
            @(posedge sys_clk_i);
            chk(8'({mode, cpu, pll, flash, hold}), 8'h17);
            chk(8'(it_en), 8'(k[0]));
            chk(8'({peri, wdet, wd_en, csb, asu}), 8'({3'h3, k[0], 1'b0}));
            enter_wake(8'h00, tbl[k][7:4]);
            wait_mode(2'h0);
            e[1] = !tbl[k][3] || tbl[k][2];
            e[0] = e[1] && (tbl[k][5:4] != 2'h0 || tbl[k][1]);
            chk(8'({cpu, ack, br}), 8'({1'b1, e[1:0]}));
        end
        enter_wake(8'h41, 4'h2);
        repeat (10) @(posedge sys_clk_i);
        chk(8'(mode), 8'h01);
        fire <= 4'h4;
        @(posedge sys_clk_i);
        fire <= 4'h0;
        wait_mode(2'h0);
        wr_reg(2'h2, 8'h00);
        wr_reg(2'h0, 8'h02);
        wr_reg(2'h1, 8'h01);
        @(posedge sys_clk_i);
        chk(8'({mode, pll, flash, osc, cpu}), 8'h22);
        enter_wake(8'h00, 4'h8);
        wait_mode(2'h3);
        n = 0;
        while (mode === 2'h3 && n < 100)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        chk(8'(n), 8'h11);
        wr_reg(2'h2, 8'h07);
        wr_reg(2'h0, 8'h00);
        wr_reg(2'h1, 8'h01);
        srst_i <= 1'b1;
        @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        chk(8'({mode, cpu}), 8'h01);
        rd_reg(2'h2, 8'h04);
        test_done();
    end
endmodule
